// ### src/pwm_timer_cfg.svh
// register map, field positions, reset values and counts of the pwm timer
`ifndef PWM_TIMER_CFG_SVH
`define PWM_TIMER_CFG_SVH

// byte offsets of the apb registers
`define OFF_MODE        8'h00
`define OFF_CYCLE       8'h04
`define OFF_DUTY        8'h08
`define OFF_STATUS      8'h0c
`define OFF_MASK        8'h10
`define OFF_COUNT       8'h14

// mode register fields
`define MODE_EN_BIT     7
`define MODE_CKS_HI     6
`define MODE_CKS_LO     4
`define MODE_OPM_HI     3
`define MODE_OPM_LO     2
`define MODE_LEV_BIT    1
`define MODE_GATE_BIT   0

// status and mask fields
`define STS_PERIOD_BIT  0
`define STS_DUTY_BIT    1
`define STS_W           2

// count register fields
`define CNT_STATE_LO    8
`define CNT_STATE_HI    9

// reset values
`define RST_MODE        8'h00
`define RST_CYCLE       8'h00
`define RST_DUTY        8'h00
`define RST_MASK        2'h0

// mode and clock select codes
`define OPM_INTERVAL    2'h0
`define OPM_PWM         2'h2
`define CKS_DIV1        3'h0
`define CKS_DIV4        3'h1
`define CKS_DIV16       3'h2
`define CKS_DIV64       3'h3
`define CKS_DIV4096     3'h4
`define CKS_LSOSC128    3'h5

// prescaler masks: divide by 4, 16, 64, 4096 and low-speed divide by 128
`define PRE_MASK4       12'h003
`define PRE_MASK16      12'h00f
`define PRE_MASK64      12'h03f
`define PRE_MASK4096    12'hfff
`define LS_MASK128      7'h7f

// count clocks between a duty write and its transfer
`define DUTY_XFER_TICKS 2'h3

`endif

// ### src/pwm_timer_pkg.sv
// types shared by the pwm timer modules
package pwm_timer_pkg;

  // mode control fields as stored
  typedef struct packed {
    logic       count_enable;
    logic [2:0] clk_sel;
    logic [1:0] timer_mode_ctl;
    logic       out_level_ctl;
    logic       out_gate;
  } mode_ctl_type;

  // compare sequencer, gray coded along idle, mask, cycle, duty
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MASK  = 2'b01,
    ST_CYCLE = 2'b11,
    ST_DUTY  = 2'b10
  } seq_state_type;

  // sticky event flags
  typedef struct packed {
    logic duty_match;
    logic period;
  } event_type;

endpackage : pwm_timer_pkg

// ### src/count_tick_gen.sv
// count clock tick generator with peripheral and low-speed sources
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timer_cfg.svh"

module count_tick_gen #(
  parameter int PRE_W = 12
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  // low-speed oscillator pin
  input  wire logic       lsosc_clk,
  // one-cycle count clock tick
  output logic            tick
);

  // elaboration check: the tick masks assume a 12-bit prescaler
  if (PRE_W != 12)
  begin : g_bad_pre
    $error("count_tick_gen: prescaler must be 12 bits");
  end

  logic [PRE_W-1:0] pre_q, pre_d;
  logic [6:0]       ls_cnt_q, ls_cnt_d;
  logic [2:0]       ls_sync_q;
  logic             tick_q, tick_d;
  logic             ls_rise;

  // true when all bits selected by the mask are ones
  function automatic logic wrapped(input logic [11:0] v, input logic [11:0] m);
    return (v & m) == m;
  endfunction : wrapped

  // edge of the synchronised oscillator, first stage not read
  assign ls_rise = ls_sync_q[1] & ~ls_sync_q[2];

  // prescalers and tick select
  always_comb
  begin
    pre_d    = run ? pre_q + 1'b1 : '0;
    ls_cnt_d = !run ? 7'h00 : (ls_rise ? ls_cnt_q + 7'h01 : ls_cnt_q);
    tick_d   = 1'b0;
    if (run)
    begin
      unique case (clk_sel) // R15
        `CKS_DIV1:     tick_d = 1'b1;
        `CKS_DIV4:     tick_d = wrapped(pre_q, `PRE_MASK4);
        `CKS_DIV16:    tick_d = wrapped(pre_q, `PRE_MASK16);
        `CKS_DIV64:    tick_d = wrapped(pre_q, `PRE_MASK64);
        `CKS_DIV4096:  tick_d = wrapped(pre_q, `PRE_MASK4096);
        `CKS_LSOSC128: tick_d = ls_rise && (ls_cnt_q == `LS_MASK128);
        default:       tick_d = 1'b0; // prohibited codes never tick
      endcase
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q     <= '0;
      ls_cnt_q  <= 7'h00;
      ls_sync_q <= 3'h0;
      tick_q    <= 1'b0;
    end
    else
    begin
      pre_q     <= pre_d;
      ls_cnt_q  <= ls_cnt_d;
      ls_sync_q <= {ls_sync_q[1:0], lsosc_clk};
      tick_q    <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : count_tick_gen
`default_nettype wire

// ### src/pwm_timer.sv
// 8-bit pwm timer with apb registers, duty latch and period interrupt
// Summary of operation
// R01 - software leaves the cycle compare untouched while counting runs
// R02 - duty compare accepts writes while counting runs
// R03 - first count tick after enable is masked; cycle compare comes first
// R04 - cycle match clears counter, sets period status, drives output active in pwm mode and toggles it in interval mode
// R05 - duty match drives output inactive, returns to cycle compare
// R06 - period is cycle plus one ticks, active width duty plus one
// R07 - software keeps duty below cycle, both within byte range
// R08 - new duty moves in at old duty match, three ticks after write
// R09 - duty writes arrive any time and are aligned to the tick internally
// R10 - software rewrites duty compare each time counting restarts
// R11 - clearing enable forces interrupt and output inactive at once
// R12 - output stays inactive until first cycle match; level bit sets it
// R13 - enable low stops and clears counter; high counts on ticks
// R14 - mode code 00 interval, 10 pwm, others prohibited
// R15 - clock field picks divide 1/4/16/64/4096 or low-speed divide 128
// R16 - gate bit passes the pulse to the pin when one
// R17 - after the masked first tick, counter steps one per tick, compared on every tick
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timer_cfg.svh"

module pwm_timer #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // low-speed oscillator pin
  input  wire logic              lsosc_clk,
  // timer output pin and interrupt
  output logic                   pulse_out,
  output logic                   period_irq
);

  // elaboration check: the register map needs a full byte of address
  if (ADDR_W < 8)
  begin : g_bad_addr
    $error("pwm_timer: address must be at least 8 bits");
  end

  pwm_timer_pkg::mode_ctl_type  mode_q, mode_d;
  pwm_timer_pkg::seq_state_type st_q, st_d;
  pwm_timer_pkg::event_type     sts_q, sts_d;
  pwm_timer_pkg::event_type     msk_q, msk_d;
  pwm_timer_pkg::event_type     ev;

  logic [7:0]  cycle_q, cycle_d;
  logic [7:0]  duty_latch_q, duty_latch_d;
  logic [7:0]  duty_act_q, duty_act_d;
  logic        dpend_q, dpend_d;
  logic [1:0]  dage_q, dage_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        active_q, active_d;
  logic        pulse_q, pulse_d;
  logic        irq_q, irq_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  logic        tick;
  logic        acc;
  logic        wr_fire;
  logic        hit_mode;
  logic        hit_cycle;
  logic        hit_duty;
  logic        hit_sts;
  logic        hit_msk;
  logic        hit_cnt;
  logic        hit_any;
  logic        pwm_mode;

  // address compare on a full aligned word
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction : reg_hit

  // count clock source
  count_tick_gen #(
    .PRE_W     (12)
  ) u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (mode_q.count_enable),
    .clk_sel   (mode_q.clk_sel),
    .lsosc_clk (lsosc_clk),
    .tick      (tick)
  );

  // apb decode; one wait state, write lands when pready is seen
  assign acc       = psel & penable;
  assign wr_fire   = acc & pready_q & pwrite;
  assign hit_mode  = reg_hit(paddr, `OFF_MODE);
  assign hit_cycle = reg_hit(paddr, `OFF_CYCLE);
  assign hit_duty  = reg_hit(paddr, `OFF_DUTY);
  assign hit_sts   = reg_hit(paddr, `OFF_STATUS);
  assign hit_msk   = reg_hit(paddr, `OFF_MASK);
  assign hit_cnt   = reg_hit(paddr, `OFF_COUNT);
  assign hit_any   = hit_mode | hit_cycle | hit_duty | hit_sts | hit_msk | hit_cnt;
  assign pwm_mode  = mode_q.timer_mode_ctl == `OPM_PWM; // R14

  // apb handshake and read data
  always_comb
  begin
    pready_d  = acc & ~pready_q;
    pslverr_d = acc & ~pready_q & ~hit_any;
    prdata_d  = prdata_q;
    if (acc && !pready_q && !pwrite)
    begin
      prdata_d = 32'h0000_0000;
      if (hit_mode)
        prdata_d[7:0] = mode_q;
      if (hit_cycle)
        prdata_d[7:0] = cycle_q;
      if (hit_duty)
        prdata_d[7:0] = duty_latch_q;
      if (hit_sts)
        prdata_d[`STS_W-1:0] = sts_q;
      if (hit_msk)
        prdata_d[`STS_W-1:0] = msk_q;
      if (hit_cnt)
        prdata_d[`CNT_STATE_HI:0] = {st_q, cnt_q};
    end
  end

  // software-owned control registers
  always_comb
  begin
    mode_d  = mode_q;
    cycle_d = cycle_q;
    msk_d   = msk_q;
    if (wr_fire && hit_mode)
    begin
      // other fields frozen while counting
      if (mode_q.count_enable)
        mode_d.count_enable = pwdata[`MODE_EN_BIT];
      else
        mode_d = pwdata[7:0];
    end
    // period register only moves while stopped
    if (wr_fire && hit_cycle && !mode_q.count_enable) // R01
      cycle_d = pwdata[7:0];
    if (wr_fire && hit_msk)
      msk_d = pwdata[`STS_W-1:0];
  end

  // compare sequencer, counter and duty transfer
  always_comb
  begin
    st_d         = st_q;
    cnt_d        = cnt_q;
    active_d     = active_q;
    duty_latch_d = duty_latch_q;
    duty_act_d   = duty_act_q;
    dpend_d      = dpend_q;
    dage_d       = dage_q;
    ev           = '0;
    if (!mode_q.count_enable)
    begin
      // stopped: counter zero, output inactive
      st_d     = pwm_timer_pkg::ST_IDLE; // R13
      cnt_d    = 8'h00; // R13
      active_d = 1'b0; // R11
      dpend_d  = 1'b0;
    end
    else
    begin
      // age pending duty in count clocks
      if (tick && dpend_q && dage_q != `DUTY_XFER_TICKS)
        dage_d = dage_q + 2'h1; // R09
      unique case (st_q)
        pwm_timer_pkg::ST_IDLE:
          st_d = pwm_timer_pkg::ST_MASK;
        pwm_timer_pkg::ST_MASK:
        begin
          // swallow one tick, then compare against the cycle first
          if (tick)
            st_d = pwm_timer_pkg::ST_CYCLE; // R03
        end
        pwm_timer_pkg::ST_CYCLE:
        begin
          if (tick)
          begin
            if (cnt_q == cycle_q) // R17
            begin
              cnt_d     = 8'h00; // R04 R06
              ev.period = 1'b1; // R04
              if (pwm_mode)
              begin
                active_d = 1'b1; // R04
                st_d     = pwm_timer_pkg::ST_DUTY; // R04
              end
              else if (mode_q.timer_mode_ctl == `OPM_INTERVAL)
                active_d = ~active_q; // square wave in interval mode
            end
            else
              cnt_d = cnt_q + 8'h01; // R17
          end
        end
        pwm_timer_pkg::ST_DUTY:
        begin
          if (tick)
          begin
            if (cnt_q == duty_act_q) // R17
            begin
              // end of active width, counter keeps running
              active_d      = 1'b0; // R05 R06
              st_d          = pwm_timer_pkg::ST_CYCLE; // R05
              ev.duty_match = 1'b1;
              cnt_d         = cnt_q + 8'h01;
              if (dpend_q && dage_q == `DUTY_XFER_TICKS)
              begin
                duty_act_d = duty_latch_q; // R08
                dpend_d    = 1'b0; // R08
              end
            end
            else
              cnt_d = cnt_q + 8'h01; // R17
          end
        end
      endcase
    end
    // a write restarts the wait; a colliding match still moves the old latched duty
    if (wr_fire && hit_duty)
    begin
      duty_latch_d = pwdata[7:0]; // R02
      if (mode_q.count_enable)
      begin
        dpend_d = 1'b1; // R08 R09
        dage_d  = 2'h0; // R08
      end
      else
      begin
        // stopped: value is live at once, ready for the next start
        duty_act_d = pwdata[7:0]; // R10
        dpend_d    = 1'b0;
      end
    end
  end

  // sticky status, mask, outputs
  always_comb
  begin
    sts_d = sts_q;
    if (wr_fire && hit_sts)
      sts_d = sts_q & ~pwdata[`STS_W-1:0];
    sts_d   = sts_d | ev; // set beats clear
    irq_d   = mode_d.count_enable & |(sts_d & msk_q); // R11
    // inactive level follows level bit, gate passes it to the pin
    pulse_d = mode_d.out_gate
              & ((active_d & mode_d.count_enable) ^ mode_d.out_level_ctl); // R12 R16 R11
  end

  // apb registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q  <= `RST_MODE;
      cycle_q <= `RST_CYCLE;
      msk_q   <= `RST_MASK;
    end
    else
    begin
      mode_q  <= mode_d;
      cycle_q <= cycle_d;
      msk_q   <= msk_d;
    end
  end

  // counting state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q         <= pwm_timer_pkg::ST_IDLE;
      cnt_q        <= 8'h00;
      active_q     <= 1'b0;
      duty_latch_q <= `RST_DUTY;
      duty_act_q   <= `RST_DUTY;
      dpend_q      <= 1'b0;
      dage_q       <= 2'h0;
    end
    else
    begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      active_q     <= active_d;
      duty_latch_q <= duty_latch_d;
      duty_act_q   <= duty_act_d;
      dpend_q      <= dpend_d;
      dage_q       <= dage_d;
    end
  end

  // status and pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts_q   <= '0;
      irq_q   <= 1'b0;
      pulse_q <= 1'b0;
    end
    else
    begin
      sts_q   <= sts_d;
      irq_q   <= irq_d;
      pulse_q <= pulse_d;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign pulse_out  = pulse_q;
  assign period_irq = irq_q;

endmodule : pwm_timer
`default_nettype wire

// ### bench/pwm_timer_checker.sv
// concurrent checks on the pwm timer ports
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timer_cfg.svh"

module pwm_timer_checker #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb slave side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // timer outputs
  input wire logic              pulse_out,
  input wire logic              period_irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ready answers an access after exactly one wait
  property p_ready_after;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_after: assert property (p_ready_after) else $error("ready late");
  property p_ready_cause;
    pready |-> $past(psel && penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  // error response only on unmapped places
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_err_unmapped;
    pready && paddr > `OFF_COUNT |-> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped accepted");
  property p_ok_mapped;
    pready && paddr <= `OFF_COUNT && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("mapped refused");
  property p_rd_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped data nonzero");
  property p_upper_zero;
    pready && !pwrite |-> prdata[31:10] == 22'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  // stopping the timer drops the interrupt promptly
  property p_irq_off;
    pready && psel && pwrite && paddr == `OFF_MODE && !pwdata[`MODE_EN_BIT]
      |-> ##[1:3] !period_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq after stop");
endmodule : pwm_timer_checker
`default_nettype wire

// ### bench/pwm_timer_tb.sv
// self-checking bench for the pwm timer over apb
`timescale 1ns/100ps
`default_nettype none
`include "pwm_timer_cfg.svh"

module pwm_timer_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lsosc_clk;
  logic        pulse_out;
  logic        period_irq;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          checked;
  int          hi;
  int          per;

  pwm_timer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lsosc_clk(lsosc_clk),
    .pulse_out(pulse_out), .period_irq(period_irq)
  );

  // 25 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // one apb transfer, entered and left just after a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // counts cycles while the pin stays at lvl, bounded
  task run_len(input logic lvl, output int cnt);
    cnt = 0;
    while (pulse_out === lvl && cnt < 2000)
    begin
      @(posedge pclk);
      cnt++;
    end
  endtask : run_len

  // one full period from a rising edge of the pin
  task measure();
    int skip;
    run_len(1'b1, skip);
    run_len(1'b0, skip);
    run_len(1'b1, hi);
    run_len(1'b0, per);
    per = per + hi;
  endtask : measure

  // program, start, and measure one waveform
  task run_case(input logic [7:0] mode, input logic [7:0] n, input logic [7:0] m,
                input int hi_e, input int per_e, input logic [1:0] sts_e);
    xfer(1'b1, `OFF_MODE, 32'h0);
    xfer(1'b1, `OFF_CYCLE, {24'h0, n});
    xfer(1'b1, `OFF_DUTY, {24'h0, m});
    xfer(1'b1, `OFF_STATUS, 32'h3);
    xfer(1'b1, `OFF_MASK, 32'h1);
    xfer(1'b1, `OFF_MODE, {24'h0, mode});
    check("pin before match", pulse_out, mode[`MODE_GATE_BIT] & mode[`MODE_LEV_BIT]);
    measure();
    check("high width", hi, hi_e);
    check("period", per, per_e);
    check("irq", period_irq, 1'b1);
    xfer(1'b0, `OFF_STATUS, 32'h0);
    check("status", rd, {30'h0, sts_e});
    xfer(1'b1, `OFF_MASK, 32'h0);
    @(posedge pclk);
    check("masked irq", period_irq, 1'b0);
  endtask : run_case

  task tally_and_finish();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // free-running low-speed oscillator, four clocks a period
  initial
  begin
    lsosc_clk = 1'b0;
    forever
    begin
      repeat (2) @(posedge pclk);
      lsosc_clk <= ~lsosc_clk;
    end
  end

  // watchdog against a hang
  initial
  begin
    #800000;
    n_mismatch++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 24; a += 4)
    begin
      xfer(1'b0, a[7:0], 32'h0);
      check("reset value", rd, 32'h0);
    end
    xfer(1'b0, 8'h18, 32'h0);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    xfer(1'b1, 8'h1c, 32'hff);
    check("unmapped write error", err, 1'b1);
    run_case(8'h89, 8'h03, 8'h01, 2, 4, 2'h3);
    run_case(8'h89, 8'h01, 8'h00, 1, 2, 2'h3);
    run_case(8'h89, 8'hff, 8'hfe, 255, 256, 2'h3);
    run_case(8'h99, 8'h03, 8'h01, 8, 16, 2'h3);
    run_case(8'ha9, 8'h02, 8'h00, 16, 48, 2'h3);
    run_case(8'hb9, 8'h01, 8'h00, 64, 128, 2'h3);
    run_case(8'h81, 8'h03, 8'h00, 4, 8, 2'h1);
    run_case(8'h8b, 8'h03, 8'h00, 3, 4, 2'h3);
    run_case(8'hd9, 8'h01, 8'h00, 512, 1024, 2'h3);
    // prohibited mode code never drives the pin active
    xfer(1'b1, `OFF_MODE, 32'h0);
    xfer(1'b1, `OFF_MODE, 32'h85);
    repeat (20) @(posedge pclk);
    check("prohibited mode pin", pulse_out, 1'b0);
    // gate low holds the pin low whatever the level bit
    xfer(1'b1, `OFF_MODE, 32'h0);
    xfer(1'b1, `OFF_MODE, 32'h8a);
    repeat (20) @(posedge pclk);
    check("gated pin", pulse_out, 1'b0);
    // duty change while running
    xfer(1'b1, `OFF_MODE, 32'h0);
    xfer(1'b1, `OFF_CYCLE, 32'h20);
    xfer(1'b1, `OFF_DUTY, 32'h2);
    xfer(1'b1, `OFF_MASK, 32'h1);
    xfer(1'b1, `OFF_MODE, 32'h89);
    measure();
    check("old duty", hi, 3);
    xfer(1'b1, `OFF_DUTY, 32'h5);
    xfer(1'b0, `OFF_DUTY, 32'h0);
    check("duty latch", rd, 32'h5);
    measure();
    measure();
    check("new duty", hi, 6);
    check("new period", per, 33);
    // stop during the active phase
    run_len(1'b0, hi);
    xfer(1'b1, `OFF_MODE, 32'h09);
    repeat (2) @(posedge pclk);
    check("pin after stop", pulse_out, 1'b0);
    check("irq after stop", period_irq, 1'b0);
    xfer(1'b0, `OFF_COUNT, 32'h0);
    check("count after stop", rd, 32'h0);
    xfer(1'b1, `OFF_STATUS, 32'h3);
    xfer(1'b0, `OFF_STATUS, 32'h0);
    check("status cleared", rd, 32'h0);
    tally_and_finish();
  end
endmodule : pwm_timer_tb

bind pwm_timer pwm_timer_checker #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pulse_out(pulse_out),
  .period_irq(period_irq)
);
`default_nettype wire
